// file: rtl/jsl_pkg.sv
/*
  Shared constants, state encodings and pin bundles for the JTAG stream
  loader. Assumes a single 125 MHz system clock.
*/
package jsl_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_MHZ = 125;
  localparam int STARTUP_MS = 500;
  localparam int STARTUP_CYC = STARTUP_MS * CLK_MHZ * 1000;
  localparam int TCK_LOW_NS = 64;
  localparam int TCK_HIGH_NS = 64;
  // Least times round up to whole cycles
  localparam int TCK_LOW_CYC = (TCK_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int TCK_HIGH_CYC = (TCK_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int MEM_ACCESS_NS = 120;
  localparam int MEM_ACCESS_CYC = (MEM_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_STAGES = 2;
  // Access time, synchroniser and one spare cycle
  localparam int MEM_WAIT_CYC = MEM_ACCESS_CYC + SYNC_STAGES + 1;

  // ************************************************************
  // Memory layout and stream format
  // ************************************************************
  localparam int ADDR_W = 32;
  localparam int BYTE_W = 8;
  localparam logic [31:0] HDR_START = 32'h0000_0000;
  localparam logic [31:0] STREAM_START = 32'h0000_0004;
  localparam int PAIRS_PER_BYTE = 4;
  localparam int TDI_BIT = 0;
  localparam int TMS_BIT = 1;
  localparam int FIFO_DEPTH = 8;

  // ************************************************************
  // Encodings and bundles
  // ************************************************************
  typedef enum logic [1:0] {
    ST_POWERUP = 2'b00,
    ST_HEADER = 2'b01,
    ST_STREAM = 2'b10,
    ST_SLEEP = 2'b11
  } jsl_state_t;

  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_LOW = 2'b01,
    SH_HIGH = 2'b10
  } jsl_shift_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jsl_link_t;

  typedef struct packed {
    logic ceN;
    logic [ADDR_W-1:0] addr;
  } jsl_mem_t;

  localparam jsl_link_t LINK_RST = 3'b000;
  localparam jsl_mem_t MEM_RST = {1'b1, 32'h0000_0000};

endpackage : jsl_pkg

// file: rtl/jsl_fifo.sv
/*
  Small first-word-fall-through FIFO with valid/ready on both sides.
  Assumes one clock; DEPTH is a power of two.
*/
`timescale 1ns/10ps
module jsl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wPtr;
  logic [AW-1:0] rPtr;
  logic [AW:0] count;
  logic doPush;
  logic doPop;

  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = store[rPtr];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  // ************************************************************
  // Storage and pointers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (doPush) begin
      store[wPtr] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wPtr <= '0;
      rPtr <= '0;
    end else begin
      if (doPush) begin
        wPtr <= wPtr + 1'b1;
      end
      if (doPop) begin
        rPtr <= rPtr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (doPush && !doPop) begin
      count <= count + 1'b1;
    end else if (doPop && !doPush) begin
      count <= count - 1'b1;
    end
  end

endmodule : jsl_fifo

// file: rtl/jsl_loader.sv
/*
  Stand-alone loader: after reset it reads an end-address header and a packed
  TMS/TDI stream from a parallel nonvolatile memory and plays it into a
  boundary-scan chain. Assumes an asynchronous-read memory whose data
  settle within the access time, and a chain that samples on TCK rise.
*/
// Overview of operation
// - Each byte gives four TCK periods.
// - Even bits TDI, odd bits TMS, ascending.
// - Stored bits driven without inversion.
// - Header holds last address plus one.
// - Header is little-endian from address zero.
// - Stream fetch starts at address four.
// - Address and end bound are 32-bit.
// - Download runs automatically after every reset.
// - Wait 500 ms before starting.
// - Init TCK low, hold host low.
// - Init chip select low, lamp on.
// - Place data, then raise and lower TCK.
// - Advance address per byte while below bound.
// - On completion release host, lamp off.
// - On completion deselect memory, then sleep.
// - Link is four scan signals plus hold.
`timescale 1ns/10ps
module jsl_loader #(
  parameter int unsigned STARTUP_CYCLES = jsl_pkg::STARTUP_CYC,
  parameter int unsigned TCK_LOW_CYCLES = jsl_pkg::TCK_LOW_CYC,
  parameter int unsigned TCK_HIGH_CYCLES = jsl_pkg::TCK_HIGH_CYC,
  parameter int unsigned MEM_WAIT_CYCLES = jsl_pkg::MEM_WAIT_CYC,
  parameter int unsigned FIFO_DEPTH = jsl_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [jsl_pkg::BYTE_W-1:0] memData,
  input wire logic tdo,
  output jsl_pkg::jsl_mem_t memOut,
  output jsl_pkg::jsl_link_t chainOut,
  output logic hostHoldN,
  output logic activityLampN,
  output logic tdoLast
);

  localparam int BW = jsl_pkg::BYTE_W;
  localparam int AW = jsl_pkg::ADDR_W;

  jsl_pkg::jsl_state_t state;
  jsl_pkg::jsl_state_t next_state;
  jsl_pkg::jsl_shift_t shState;
  logic [31:0] startCnt;
  logic [BW-1:0] memMeta;
  logic [BW-1:0] memSync;
  logic tdoMeta;
  logic tdoSync;
  logic [AW-1:0] addr;
  logic [AW-1:0] endBound;
  logic fetchBusy;
  logic [7:0] fetchCnt;
  logic fetchGo;
  logic fetchDone;
  logic pushValid;
  logic [BW-1:0] pushData;
  logic fifoInReady;
  logic fifoOutValid;
  logic [BW-1:0] fifoOutData;
  logic popReady;
  logic [BW-1:0] shByte;
  logic [1:0] pairIdx;
  logic [7:0] phaseCnt;
  logic active;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // Memory data is quasi-static while the address is held, so a
  // per-bit two-stage synchroniser is safe within the wait count.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memMeta <= '0;
      memSync <= '0;
      tdoMeta <= 1'b0;
      tdoSync <= 1'b0;
    end else begin
      memMeta <= memData;
      memSync <= memMeta;
      tdoMeta <= tdo;
      tdoSync <= tdoMeta;
    end
  end

  // ************************************************************
  // Top-level sequence
  // ************************************************************
  always_comb begin
    next_state = state;
    case (state)
      jsl_pkg::ST_POWERUP: begin
        if (startCnt >= STARTUP_CYCLES - 1) begin
          next_state = jsl_pkg::ST_HEADER;
        end
      end
      jsl_pkg::ST_HEADER: begin
        if (addr == jsl_pkg::STREAM_START && !fetchBusy) begin
          if (endBound > jsl_pkg::STREAM_START) begin
            next_state = jsl_pkg::ST_STREAM;
          end else begin
            next_state = jsl_pkg::ST_SLEEP;
          end
        end
      end
      jsl_pkg::ST_STREAM: begin
        if (addr >= endBound && !fetchBusy && !pushValid &&
            !fifoOutValid && shState == jsl_pkg::SH_IDLE) begin
          next_state = jsl_pkg::ST_SLEEP;
        end
      end
      jsl_pkg::ST_SLEEP: begin
        next_state = jsl_pkg::ST_SLEEP;
      end
      default: begin
        next_state = jsl_pkg::ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= jsl_pkg::ST_POWERUP;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      startCnt <= '0;
    end else if (state == jsl_pkg::ST_POWERUP) begin
      startCnt <= startCnt + 32'h0000_0001;
    end
  end

  assign active = (next_state == jsl_pkg::ST_HEADER) ||
                  (next_state == jsl_pkg::ST_STREAM);

  // ************************************************************
  // Host hold, lamp and memory select
  // ************************************************************
  // hold host through transfer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hostHoldN <= 1'b1;
      activityLampN <= 1'b1;
    end else begin
      hostHoldN <= !active;
      activityLampN <= !active;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memOut <= jsl_pkg::MEM_RST;
    end else begin
      memOut.ceN <= !active;
      if (fetchGo) begin
        memOut.addr <= addr;
      end
    end
  end

  // ************************************************************
  // Memory fetch
  // ************************************************************
  // One outstanding byte; the pending push blocks the next fetch.
  assign fetchGo = !fetchBusy && !pushValid && (
    (state == jsl_pkg::ST_HEADER && addr < jsl_pkg::STREAM_START) ||
    (state == jsl_pkg::ST_STREAM && addr < endBound && fifoInReady));
  assign fetchDone = fetchBusy && (fetchCnt == 8'h00);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fetchBusy <= 1'b0;
      fetchCnt <= 8'h00;
    end else if (fetchGo) begin
      fetchBusy <= 1'b1;
      fetchCnt <= 8'(MEM_WAIT_CYCLES - 1);
    end else if (fetchBusy) begin
      if (fetchCnt == 8'h00) begin
        fetchBusy <= 1'b0;
      end else begin
        fetchCnt <= fetchCnt - 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr <= jsl_pkg::HDR_START;
    end else if (fetchDone) begin
      addr <= addr + 32'h0000_0001;
    end
  end

  // byte at address zero is LSB
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      endBound <= '0;
    end else if (fetchDone && state == jsl_pkg::ST_HEADER) begin
      endBound[addr[1:0]*BW +: BW] <= memSync;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pushValid <= 1'b0;
      pushData <= '0;
    end else if (fetchDone && state == jsl_pkg::ST_STREAM) begin
      pushValid <= 1'b1;
      pushData <= memSync;
    end else if (fifoInReady) begin
      pushValid <= 1'b0;
    end
  end

  // ************************************************************
  // Byte buffer
  // ************************************************************
  // Shifter stalls the buffer; a full buffer stalls fetching.
  jsl_fifo #(
    .WIDTH(BW),
    .DEPTH(FIFO_DEPTH)
  ) i_jsl_fifo (
    .clk(clk),
    .rst(rst),
    .inValid(pushValid),
    .inData(pushData),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOutData),
    .outReady(popReady)
  );

  assign popReady = (state == jsl_pkg::ST_STREAM) &&
                    (shState == jsl_pkg::SH_IDLE);

  // ************************************************************
  // Chain shifter
  // ************************************************************
  // Data changes only while TCK is low, a full low phase before rise.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shState <= jsl_pkg::SH_IDLE;
      chainOut <= jsl_pkg::LINK_RST;
      shByte <= '0;
      pairIdx <= 2'b00;
      phaseCnt <= 8'h00;
    end else begin
      case (shState)
        jsl_pkg::SH_IDLE: begin
          chainOut.tck <= 1'b0;
          if (popReady && fifoOutValid) begin
            // first pair is bits 0 and 1
            chainOut.tdi <= fifoOutData[jsl_pkg::TDI_BIT];
            chainOut.tms <= fifoOutData[jsl_pkg::TMS_BIT];
            shByte <= fifoOutData >> 2;
            pairIdx <= 2'b00;
            phaseCnt <= 8'(TCK_LOW_CYCLES - 1);
            shState <= jsl_pkg::SH_LOW;
          end
        end
        jsl_pkg::SH_LOW: begin
          if (phaseCnt == 8'h00) begin
            chainOut.tck <= 1'b1;
            phaseCnt <= 8'(TCK_HIGH_CYCLES - 1);
            shState <= jsl_pkg::SH_HIGH;
          end else begin
            phaseCnt <= phaseCnt - 8'h01;
          end
        end
        jsl_pkg::SH_HIGH: begin
          if (phaseCnt == 8'h00) begin
            chainOut.tck <= 1'b0;
            if (pairIdx == 2'(jsl_pkg::PAIRS_PER_BYTE - 1)) begin
              shState <= jsl_pkg::SH_IDLE;
            end else begin
              chainOut.tdi <= shByte[jsl_pkg::TDI_BIT];
              chainOut.tms <= shByte[jsl_pkg::TMS_BIT];
              shByte <= shByte >> 2;
              pairIdx <= pairIdx + 2'b01;
              phaseCnt <= 8'(TCK_LOW_CYCLES - 1);
              shState <= jsl_pkg::SH_LOW;
            end
          end else begin
            phaseCnt <= phaseCnt - 8'h01;
          end
        end
        default: begin
          shState <= jsl_pkg::SH_IDLE;
          chainOut.tck <= 1'b0;
        end
      endcase
    end
  end

  // fourth scan signal sampled
  // Chain return data is only observed, never checked.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tdoLast <= 1'b0;
    end else if (shState == jsl_pkg::SH_LOW && phaseCnt == 8'h00) begin
      tdoLast <= tdoSync;
    end
  end

endmodule : jsl_loader

// file: testbench/jsl_loader_sva.sv
/*
  Port checker for the stream loader, bound to jsl_loader.
  Assumes default phase counts of 8 clocks for both TCK phases.
*/
`timescale 1ns/10ps
module jsl_loader_chk #(
  parameter int unsigned STARTUP_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] memData,
  input wire logic tdo,
  input wire jsl_pkg::jsl_mem_t memOut,
  input wire jsl_pkg::jsl_link_t chainOut,
  input wire logic hostHoldN,
  input wire logic activityLampN,
  input wire logic tdoLast
);
  // ************************************************************
  // Helper logic
  // ************************************************************
  logic [31:0] sinceRst;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sinceRst <= 32'h0;
    end else if (sinceRst != 32'hffff_ffff) begin
      sinceRst <= sinceRst + 32'h1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ************************************************************
  // Properties
  // ************************************************************
  property p_start_wait;
    $fell(hostHoldN) |-> sinceRst >= STARTUP_CYCLES &&
      sinceRst <= STARTUP_CYCLES + 2;
  endproperty
  a_start_wait: assert property (p_start_wait)
    else $error("start-up wait length wrong");
  property p_ctl_together;
    hostHoldN == activityLampN && memOut.ceN == activityLampN;
  endproperty
  a_ctl_together: assert property (p_ctl_together)
    else $error("hold, lamp and select differ");
  property p_tck_when_held;
    chainOut.tck |-> !hostHoldN && !memOut.ceN;
  endproperty
  a_tck_when_held: assert property (p_tck_when_held)
    else $error("test clock pulsed while host free");
  property p_tck_high;
    $rose(chainOut.tck) |-> chainOut.tck[*8] ##1 !chainOut.tck;
  endproperty
  a_tck_high: assert property (p_tck_high)
    else $error("test clock high phase wrong");
  property p_tck_low;
    $fell(chainOut.tck) |-> !chainOut.tck[*8];
  endproperty
  a_tck_low: assert property (p_tck_low)
    else $error("test clock low phase too short");
  property p_data_stable;
    chainOut.tck |-> $stable({chainOut.tms, chainOut.tdi});
  endproperty
  a_data_stable: assert property (p_data_stable)
    else $error("scan data moved while clock high");
  property p_addr_step;
    $changed(memOut.addr) |-> memOut.addr == $past(memOut.addr) + 32'h1;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("address did not step by one");
  property p_stream_addr;
    $rose(chainOut.tck) |-> memOut.addr >= 32'h4;
  endproperty
  a_stream_addr: assert property (p_stream_addr)
    else $error("clock pulse before stream address");
  property p_sleep;
    $rose(hostHoldN) |=>
      (hostHoldN && !chainOut.tck && $stable(memOut))[*8];
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("activity after completion");
endmodule : jsl_loader_chk

bind jsl_loader jsl_loader_chk #(.STARTUP_CYCLES(STARTUP_CYCLES))
  i_jsl_loader_chk (.clk(clk), .rst(rst), .memData(memData), .tdo(tdo),
  .memOut(memOut), .chainOut(chainOut), .hostHoldN(hostHoldN),
  .activityLampN(activityLampN), .tdoLast(tdoLast));

// file: testbench/jsl_mem_chain_model.sv
/*
  Model of the parallel memory and the scan chain beside the loader.
  Assumes the bench fills mem before the loader leaves reset.
*/
`timescale 1ns/10ps
module jsl_mem_chain_model (
  input wire jsl_pkg::jsl_mem_t memOut,
  input wire jsl_pkg::jsl_link_t chainOut,
  output logic [7:0] memData,
  output logic tdo
);
  logic [7:0] mem [0:63];
  logic [1:0] pairQ [$];
  initial begin
    memData = 8'h00;
    tdo = 1'b0;
  end
  // Stale data inverted for 100 ns, so early capture shows
  always @(memOut) begin
    memData = ~memData;
    memData <= #100 (memOut.ceN ? ~memData : mem[memOut.addr[5:0]]);
  end
  always @(posedge chainOut.tck) begin
    pairQ.push_back({chainOut.tms, chainOut.tdi});
  end
  always @(negedge chainOut.tck) begin
    tdo <= ~tdo;
  end
endmodule : jsl_mem_chain_model

// file: testbench/jsl_loader_test.sv
/*
  Self-checking bench for the stream loader.
  Assumes the memory and chain model beside it and the bound checker.
*/
`timescale 1ns/10ps
module jsl_loader_test;
  localparam int SU = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] memData;
  logic tdo;
  jsl_pkg::jsl_mem_t memOut;
  jsl_pkg::jsl_link_t chainOut;
  logic hostHoldN;
  logic activityLampN;
  logic tdoLast;
  int errCount = 0;
  int checkCount = 0;

  always #4 clk = ~clk;

  jsl_loader #(.STARTUP_CYCLES(SU)) i_jsl_loader (.clk(clk), .rst(rst),
    .memData(memData), .tdo(tdo), .memOut(memOut), .chainOut(chainOut),
    .hostHoldN(hostHoldN), .activityLampN(activityLampN),
    .tdoLast(tdoLast));
  jsl_mem_chain_model i_jsl_mem_chain_model (.memOut(memOut),
    .chainOut(chainOut), .memData(memData), .tdo(tdo));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [7:0] pat(input int i);
    return (8'(i) * 8'h35) ^ 8'h1b;
  endfunction : pat

  task automatic load_image(input logic [31:0] bound);
    for (int i = 0; i < 64; i++) i_jsl_mem_chain_model.mem[i] = pat(i);
    for (int i = 0; i < 4; i++) i_jsl_mem_chain_model.mem[i] = bound[8*i+:8];
  endtask : load_image

  task automatic pulse_reset;
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    i_jsl_mem_chain_model.pairQ.delete();
  endtask : pulse_reset

  // Polled one step after the edge, once the outputs have settled
  task automatic wait_done;
    int n;
    n = 0;
    while (activityLampN !== 1'b0 && n < SU + 10) begin
      #8;
      n++;
    end
    check({memOut.ceN, hostHoldN, activityLampN}, 3'b000);
    check(chainOut.tck, 1'b0);
    while (activityLampN !== 1'b1 && n < 20000) begin
      #8;
      n++;
    end
    #24;
    check({memOut.ceN, hostHoldN, activityLampN}, 3'b111);
    check(chainOut.tck, 1'b0);
  endtask : wait_done

  task automatic check_pairs(input int nb);
    logic [7:0] b;
    logic [1:0] pairExp;
    int n;
    n = i_jsl_mem_chain_model.pairQ.size();
    check(n, 4 * nb);
    for (int k = 0; k < n && k < 4 * nb; k++) begin
      b = pat(4 + k / 4);
      pairExp = {b[2*(k%4)+1], b[2*(k%4)]};
      check(i_jsl_mem_chain_model.pairQ[k], pairExp);
    end
    // Last capture precedes the final fall, which toggles the return bit
    check(tdoLast, !i_jsl_mem_chain_model.tdo);
  endtask : check_pairs

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Twelve bytes, more than the FIFO holds
  task automatic test_stream;
    load_image(32'd16);
    pulse_reset;
    #8 check({memOut.ceN, hostHoldN, activityLampN}, 3'b111);
    wait_done;
    check_pairs(12);
  endtask : test_stream

  task automatic test_short;
    logic [31:0] bounds [3];
    bounds = '{32'd0, 32'd3, 32'd4};
    foreach (bounds[i]) begin
      load_image(bounds[i]);
      pulse_reset;
      wait_done;
      check(i_jsl_mem_chain_model.pairQ.size(), 0);
      check(tdoLast, 1'b0);
    end
  endtask : test_short

  // Reset in mid-stream must restart from the header
  task automatic test_restart;
    int n;
    load_image(32'd10);
    pulse_reset;
    n = 0;
    while (i_jsl_mem_chain_model.pairQ.size() < 5 && n < 5000) begin
      #8;
      n++;
    end
    check(i_jsl_mem_chain_model.pairQ.size(), 5);
    pulse_reset;
    wait_done;
    check_pairs(6);
  endtask : test_restart

  // ************************************************************
  // Run control
  // ************************************************************
  task automatic tallyAndFinish;
    if (errCount == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tallyAndFinish

  initial begin
    #(40000 * 8);
    errCount++;
    tallyAndFinish;
  end

  initial begin
    test_stream;
    test_short;
    test_restart;
    tallyAndFinish;
  end
endmodule : jsl_loader_test
